// >>> hw/gpio_regs.svh
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH
`define PORT_A_WIDTH      5
`define PORT_BC_WIDTH     8
`define PORT_A_LATCH_RST  5'h1F
`define PORT_DIR_RST      8'h00
`define PORT_IE_RST       8'hFF
`define PORT_DATA_RST     8'h00
`define PORT_A_UNDEF_FILL 3'h7
`define SEL_A_LATCH       3'h0
`define SEL_A_PIN         3'h1
`define SEL_B_DATA        3'h2
`define SEL_B_DIR         3'h3
`define SEL_B_IE          3'h4
`define SEL_C_DATA        3'h5
`define SEL_C_DIR         3'h6
`define SEL_C_IE          3'h7
`endif

// >>> hw/gpio_pkg.sv
`default_nettype none
package gpio_pkg;
  typedef enum logic [2:0] {
    REG_A_LATCH = 3'h0,
    REG_A_PIN   = 3'h1,
    REG_B_DATA  = 3'h2,
    REG_B_DIR   = 3'h3,
    REG_B_IE    = 3'h4,
    REG_C_DATA  = 3'h5,
    REG_C_DIR   = 3'h6,
    REG_C_IE    = 3'h7
  } reg_sel_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    reg_sel_t   sel;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;
endpackage : gpio_pkg
`default_nettype wire

// >>> hw/gpio_bit_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.svh"
module gpio_bit_port #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             wr_data_in,
  input  wire logic             wr_dir_in,
  input  wire logic             wr_ie_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic [WIDTH-1:0] pin_sync_in,
  output var  logic [WIDTH-1:0] read_out,
  output var  logic [WIDTH-1:0] dir_out,
  output var  logic [WIDTH-1:0] ie_out,
  output var  logic [WIDTH-1:0] pin_o_out,
  output var  logic [WIDTH-1:0] pin_oe_n_out
);
  logic [WIDTH-1:0] data_q, data_d, dir_q, dir_d, ie_q, ie_d;

  always_comb begin
    data_d = wr_data_in ? wdata_in : data_q;
    dir_d  = wr_dir_in  ? wdata_in : dir_q;
    ie_d   = wr_ie_in   ? wdata_in : ie_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_q <= WIDTH'(`PORT_DATA_RST); // [RQ7] [RQ15]
      dir_q  <= WIDTH'(`PORT_DIR_RST);
      ie_q   <= WIDTH'(`PORT_IE_RST);
    end else begin
      data_q <= data_d;
      dir_q  <= dir_d;
      ie_q   <= ie_d;
    end
  end

  // Direction wins; a disabled input reads zero so analog pins never toggle logic
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      read_out[i] = dir_q[i] ? data_q[i] : (ie_q[i] & pin_sync_in[i]); // [RQ8] [RQ16]
    end
  end

  assign dir_out      = dir_q;
  assign ie_out       = ie_q;
  assign pin_o_out    = data_q;
  assign pin_oe_n_out = ~dir_q; // [RQ20] [RQ6]
endmodule : gpio_bit_port
`default_nettype wire

// >>> hw/gpio_ports.sv
// Behaviour
// (RQ1) First port: five two-way pins, one latch bit each, shared with serial bus.
// (RQ2) First port latch resets to all ones.
// (RQ3) Software writes one to latch for inputs and serial bus lines.
// (RQ4) First port latch and pin levels read at separate selects.
// (RQ5) First port reads return bits 7 to 5 undefined.
// (RQ6) Second port: eight pins with per-bit direction and input enable.
// (RQ7) Second port resets to direction zero, input enable one, latch zero.
// (RQ8) Second port read: zero, pin level, or latch by direction and enable.
// (RQ9) Software sets direction one to drive second port pin from latch.
// (RQ10) Software clears direction then sets wakeup select for key wakeup.
// (RQ11) Software clears direction then input enable for analog inputs.
// (RQ12) Software never sets analog second port pins to output.
// (RQ13) Software should avoid port writes during analog conversion.
// (RQ14) Bit writes use live input levels, overwriting input pins' latches.
// (RQ15) Third port resets to direction zero, input enable one, latch zero.
// (RQ16) Third port read: zero, pin level, or latch by direction and enable.
// (RQ17) Software configures third port digital inputs with direction zero, enable one.
// (RQ18) Software sets direction one for output, clears both for analog.
// (RQ19) Software clears third port input enable for analog inputs.
// (RQ20) Second and third port drivers enabled only while direction is one.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.svh"
module gpio_ports #(
  parameter int A_WIDTH  = `PORT_A_WIDTH,
  parameter int BC_WIDTH = `PORT_BC_WIDTH
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire gpio_pkg::reg_req_t req_in,
  input  wire logic              bit_op_in,
  input  wire logic [2:0]        bit_idx_in,
  input  wire logic              bit_val_in,
  output var  gpio_pkg::reg_rsp_t rsp_out,
  input  wire logic [A_WIDTH-1:0]  port_a_pin_in,
  output var  logic [A_WIDTH-1:0]  port_a_pin_o_out,
  output var  logic [A_WIDTH-1:0]  port_a_pin_oe_n_out,
  input  wire logic [BC_WIDTH-1:0] port_b_pin_in,
  output var  logic [BC_WIDTH-1:0] port_b_pin_o_out,
  output var  logic [BC_WIDTH-1:0] port_b_pin_oe_n_out,
  input  wire logic [BC_WIDTH-1:0] port_c_pin_in,
  output var  logic [BC_WIDTH-1:0] port_c_pin_o_out,
  output var  logic [BC_WIDTH-1:0] port_c_pin_oe_n_out,
  output var  logic [BC_WIDTH-1:0] port_b_input_enable_out,
  output var  logic [BC_WIDTH-1:0] port_c_input_enable_out
);
  import gpio_pkg::*;

  logic [A_WIDTH-1:0]  a_meta_q;
  logic [A_WIDTH-1:0]  a_sync_q;
  logic [A_WIDTH-1:0]  latch_a_q;
  logic [A_WIDTH-1:0]  latch_a_d;
  logic [BC_WIDTH-1:0] b_meta_q;
  logic [BC_WIDTH-1:0] b_sync_q;
  logic [BC_WIDTH-1:0] c_meta_q;
  logic [BC_WIDTH-1:0] c_sync_q;
  logic [BC_WIDTH-1:0] b_read;
  logic [BC_WIDTH-1:0] c_read;
  logic [BC_WIDTH-1:0] b_dir;
  logic [BC_WIDTH-1:0] c_dir;
  logic [BC_WIDTH-1:0] b_ie;
  logic [BC_WIDTH-1:0] c_ie;
  logic [BC_WIDTH-1:0] b_o;
  logic [BC_WIDTH-1:0] c_o;
  logic [BC_WIDTH-1:0] b_oen;
  logic [BC_WIDTH-1:0] c_oen;
  logic [7:0]          a_latch_rd;
  logic [7:0]          a_pin_rd;
  logic [7:0]          cur_rd;
  logic [7:0]          eff_wdata;
  logic                eff_wr;
  logic                wr_b_data;
  logic                wr_b_dir;
  logic                wr_b_ie;
  logic                wr_c_data;
  logic                wr_c_dir;
  logic                wr_c_ie;
  reg_rsp_t            rsp_d;
  reg_rsp_t            rsp_q;
  logic [A_WIDTH-1:0]  a_o_d;
  logic [A_WIDTH-1:0]  a_o_q;
  logic [A_WIDTH-1:0]  a_oen_d;
  logic [A_WIDTH-1:0]  a_oen_q;
  logic [BC_WIDTH-1:0] b_o_d;
  logic [BC_WIDTH-1:0] b_o_q;
  logic [BC_WIDTH-1:0] b_oen_d;
  logic [BC_WIDTH-1:0] b_oen_q;
  logic [BC_WIDTH-1:0] c_o_d;
  logic [BC_WIDTH-1:0] c_o_q;
  logic [BC_WIDTH-1:0] c_oen_d;
  logic [BC_WIDTH-1:0] c_oen_q;
  logic [BC_WIDTH-1:0] b_ie_d;
  logic [BC_WIDTH-1:0] b_ie_q;
  logic [BC_WIDTH-1:0] c_ie_d;
  logic [BC_WIDTH-1:0] c_ie_q;

  // Pins are asynchronous: two stages before anyone reads them
  always_ff @(posedge clk_in) begin
    a_meta_q <= port_a_pin_in;
    a_sync_q <= a_meta_q;
    b_meta_q <= port_b_pin_in;
    b_sync_q <= b_meta_q;
    c_meta_q <= port_c_pin_in;
    c_sync_q <= c_meta_q;
  end

  // Undefined upper bits return a fixed fill
  assign a_latch_rd = {`PORT_A_UNDEF_FILL, latch_a_q}; // [RQ5]
  assign a_pin_rd   = {`PORT_A_UNDEF_FILL, a_sync_q}; // [RQ4] [RQ5]

  always_comb begin
    case (req_in.sel)
      REG_A_LATCH: cur_rd = a_latch_rd;
      REG_A_PIN:   cur_rd = a_pin_rd;
      REG_B_DATA:  cur_rd = b_read;
      REG_B_DIR:   cur_rd = b_dir;
      REG_B_IE:    cur_rd = b_ie;
      REG_C_DATA:  cur_rd = c_read;
      REG_C_DIR:   cur_rd = c_dir;
      REG_C_IE:    cur_rd = c_ie;
      default:     cur_rd = 8'h00;
    endcase
  end

  // Bit write is read-modify-write on the read view, so enabled input pins' live
  // levels land in their latches, exactly as the CPU's bit ops behave
  always_comb begin
    eff_wdata = req_in.wdata;
    if (bit_op_in) begin
      eff_wdata = cur_rd; // [RQ14]
      eff_wdata[bit_idx_in] = bit_val_in;
    end
    eff_wr = req_in.wr | bit_op_in;
  end

  // One strobe per sub-port register, decoded once
  always_comb begin
    wr_b_data = eff_wr && req_in.sel == REG_B_DATA;
    wr_b_dir  = eff_wr && req_in.sel == REG_B_DIR;
    wr_b_ie   = eff_wr && req_in.sel == REG_B_IE;
    wr_c_data = eff_wr && req_in.sel == REG_C_DATA;
    wr_c_dir  = eff_wr && req_in.sel == REG_C_DIR;
    wr_c_ie   = eff_wr && req_in.sel == REG_C_IE;
  end

  always_comb begin
    latch_a_d = latch_a_q;
    if (eff_wr && req_in.sel == REG_A_LATCH) begin
      latch_a_d = eff_wdata[A_WIDTH-1:0];
    end
    rsp_d.valid = req_in.rd;
    rsp_d.rdata = req_in.rd ? cur_rd : 8'h00;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      latch_a_q <= A_WIDTH'(`PORT_A_LATCH_RST); // [RQ2]
      rsp_q     <= '0;
    end else begin
      latch_a_q <= latch_a_d;
      rsp_q     <= rsp_d;
    end
  end

  gpio_bit_port #(.WIDTH(BC_WIDTH)) u_port_b (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_data_in   (wr_b_data),
    .wr_dir_in    (wr_b_dir),
    .wr_ie_in     (wr_b_ie),
    .wdata_in     (eff_wdata),
    .pin_sync_in  (b_sync_q),
    .read_out     (b_read),
    .dir_out      (b_dir),
    .ie_out       (b_ie),
    .pin_o_out    (b_o),
    .pin_oe_n_out (b_oen)
  );

  gpio_bit_port #(.WIDTH(BC_WIDTH)) u_port_c (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_data_in   (wr_c_data),
    .wr_dir_in    (wr_c_dir),
    .wr_ie_in     (wr_c_ie),
    .wdata_in     (eff_wdata),
    .pin_sync_in  (c_sync_q),
    .read_out     (c_read),
    .dir_out      (c_dir),
    .ie_out       (c_ie),
    .pin_o_out    (c_o),
    .pin_oe_n_out (c_oen)
  );

  // Pin outputs registered once more so every output is a flop; costs one cycle
  always_comb begin
    // Open drain: a latch one releases the line for input or serial bus use
    a_o_d   = '0; // [RQ1]
    a_oen_d = latch_a_q; // [RQ1]
    b_o_d   = b_o;
    b_oen_d = b_oen; // [RQ20]
    c_o_d   = c_o;
    c_oen_d = c_oen; // [RQ20]
    b_ie_d  = b_ie;
    c_ie_d  = c_ie;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // Open drain never drives high, not even in reset
      a_o_q   <= '0;
      a_oen_q <= '1;
      b_o_q   <= '0;
      b_oen_q <= '1;
      c_o_q   <= '0;
      c_oen_q <= '1;
      b_ie_q  <= BC_WIDTH'(`PORT_IE_RST);
      c_ie_q  <= BC_WIDTH'(`PORT_IE_RST);
    end else begin
      a_o_q   <= a_o_d;
      a_oen_q <= a_oen_d;
      b_o_q   <= b_o_d;
      b_oen_q <= b_oen_d;
      c_o_q   <= c_o_d;
      c_oen_q <= c_oen_d;
      b_ie_q  <= b_ie_d;
      c_ie_q  <= c_ie_d;
    end
  end

  assign rsp_out                 = rsp_q;
  assign port_a_pin_o_out        = a_o_q;
  assign port_a_pin_oe_n_out     = a_oen_q;
  assign port_b_pin_o_out        = b_o_q;
  assign port_b_pin_oe_n_out     = b_oen_q;
  assign port_c_pin_o_out        = c_o_q;
  assign port_c_pin_oe_n_out     = c_oen_q;
  assign port_b_input_enable_out = b_ie_q;
  assign port_c_input_enable_out = c_ie_q;
endmodule : gpio_ports
`default_nettype wire

// >>> dv/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic [4:0] a_oe_n_in,
  input  wire logic [4:0] a_ext_in,
  input  wire logic [7:0] b_o_in,
  input  wire logic [7:0] b_oe_n_in,
  input  wire logic [7:0] b_ext_in,
  input  wire logic [7:0] c_o_in,
  input  wire logic [7:0] c_oe_n_in,
  input  wire logic [7:0] c_ext_in,
  output logic      [4:0] a_pin_out,
  output logic      [7:0] b_pin_out,
  output logic      [7:0] c_pin_out
);
  // Pulled-up line: low if either side sinks it
  assign a_pin_out = a_ext_in & a_oe_n_in;
  assign b_pin_out = (b_oe_n_in & b_ext_in) | (~b_oe_n_in & b_o_in);
  assign c_pin_out = (c_oe_n_in & c_ext_in) | (~c_oe_n_in & c_o_in);
endmodule : pin_model
`default_nettype wire

// >>> dv/gpio_ports_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_chk #(
  parameter int A_WIDTH  = 5,
  parameter int BC_WIDTH = 8
) (
  input wire logic                clk_in,
  input wire logic                rst_in,
  input wire gpio_pkg::reg_req_t  req_in,
  input wire logic                bit_op_in,
  input wire gpio_pkg::reg_rsp_t  rsp_out,
  input wire logic [A_WIDTH-1:0]  port_a_pin_in,
  input wire logic [A_WIDTH-1:0]  port_a_pin_o_out,
  input wire logic [A_WIDTH-1:0]  port_a_pin_oe_n_out,
  input wire logic [BC_WIDTH-1:0] port_b_pin_o_out,
  input wire logic [BC_WIDTH-1:0] port_b_pin_oe_n_out,
  input wire logic [BC_WIDTH-1:0] port_b_input_enable_out,
  input wire logic [BC_WIDTH-1:0] port_c_pin_oe_n_out
);
  import gpio_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic wr_ok;
  assign wr_ok = req_in.wr && !bit_op_in;
  sequence s_held;
    rst_in [*2];
  endsequence
  // Sync delay only hidden once pins sit still
  sequence s_a_quiet;
    $stable(port_a_pin_in) [*4] ##0 (req_in.rd && req_in.sel == REG_A_PIN);
  endsequence
  AST_A_RST: assert property (disable iff (1'b0) s_held |=> &port_a_pin_oe_n_out)
    else $error("port a latch not ones in reset");
  AST_B_RST: assert property (disable iff (1'b0) s_held |=>
    port_b_pin_oe_n_out == 8'hFF && port_b_pin_o_out == 8'h00 && port_b_input_enable_out == 8'hFF)
    else $error("port b reset state wrong");
  AST_A_OD: assert property (port_a_pin_o_out == '0)
    else $error("port a drives high");
  AST_RSP: assert property (!bit_op_in |=> rsp_out.valid == $past(req_in.rd))
    else $error("read response timing wrong");
  AST_A_PIN: assert property (s_a_quiet |=> rsp_out.rdata[4:0] == $past(port_a_pin_in))
    else $error("port a pin read wrong");
  AST_A_HI: assert property (req_in.rd && req_in.sel inside {REG_A_LATCH, REG_A_PIN} |=>
    rsp_out.rdata[7:5] == 3'h7)
    else $error("port a upper bits wrong");
  AST_B_OE: assert property (wr_ok && req_in.sel == REG_B_DIR |=> ##1
    port_b_pin_oe_n_out == ~$past(req_in.wdata, 2))
    else $error("port b driver enable wrong");
  AST_C_OE: assert property (wr_ok && req_in.sel == REG_C_DIR |-> ##2
    port_c_pin_oe_n_out == ~$past(req_in.wdata, 2))
    else $error("port c driver enable wrong");
endmodule : gpio_ports_chk
bind gpio_ports gpio_ports_chk #(.A_WIDTH(A_WIDTH), .BC_WIDTH(BC_WIDTH)) chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .bit_op_in(bit_op_in),
  .rsp_out(rsp_out), .port_a_pin_in(port_a_pin_in), .port_a_pin_o_out(port_a_pin_o_out),
  .port_a_pin_oe_n_out(port_a_pin_oe_n_out), .port_b_pin_o_out(port_b_pin_o_out),
  .port_b_pin_oe_n_out(port_b_pin_oe_n_out),
  .port_b_input_enable_out(port_b_input_enable_out), .port_c_pin_oe_n_out(port_c_pin_oe_n_out));
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", n, e, a); end end
module tb;
  import gpio_pkg::*;
  logic       clk_in, rst_in, bit_op_in, bit_val_in, c;
  logic [2:0] bit_idx_in, i;
  reg_req_t   req_in;
  reg_rsp_t   rsp_out;
  reg_sel_t   s;
  logic [4:0] a_pin, a_o, a_oe_n, a_ext;
  logic [7:0] b_pin, b_o, b_oe_n, b_ie, b_ext, c_pin, c_o, c_oe_n, c_ie, c_ext;
  logic [7:0] dir, ie, lat, ext;
  int         error_cnt = 0;
  int         check_count = 0;
  gpio_ports dut_u (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .bit_op_in(bit_op_in),
    .bit_idx_in(bit_idx_in), .bit_val_in(bit_val_in), .rsp_out(rsp_out),
    .port_a_pin_in(a_pin), .port_a_pin_o_out(a_o), .port_a_pin_oe_n_out(a_oe_n),
    .port_b_pin_in(b_pin), .port_b_pin_o_out(b_o), .port_b_pin_oe_n_out(b_oe_n),
    .port_c_pin_in(c_pin), .port_c_pin_o_out(c_o), .port_c_pin_oe_n_out(c_oe_n),
    .port_b_input_enable_out(b_ie), .port_c_input_enable_out(c_ie));
  pin_model pins_u (.a_oe_n_in(a_oe_n), .a_ext_in(a_ext), .b_o_in(b_o), .b_oe_n_in(b_oe_n),
    .b_ext_in(b_ext), .c_o_in(c_o), .c_oe_n_in(c_oe_n), .c_ext_in(c_ext),
    .a_pin_out(a_pin), .b_pin_out(b_pin), .c_pin_out(c_pin));
  function automatic logic [7:0] view(input logic [7:0] d, e, l, p);
    return (d & l) | (~d & e & p);
  endfunction : view
  task automatic cyc();
    @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic wr(input reg_sel_t t, input logic [7:0] d);
    cyc();
    req_in = '{wr: 1'b1, rd: 1'b0, sel: t, wdata: d};
    cyc();
    req_in.wr = 1'b0;
  endtask : wr
  task automatic rd(input reg_sel_t t, input logic [7:0] e, input string n);
    cyc();
    req_in.sel = t;
    req_in.rd = 1'b1;
    cyc();
    req_in.rd = 1'b0;
    `CHK(n, {1'b1, e}, rsp_out)
  endtask : rd
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h4E30));
    {rst_in, req_in, bit_op_in, bit_idx_in, bit_val_in} = '0;
    rst_in = 1'b1;
    {a_ext, b_ext, c_ext} = '1;
    repeat (10) @(posedge clk_in);
    #1 rst_in = 1'b0;
    rd(REG_A_LATCH, 8'hFF, "a latch");
    // Data reads show the pulled-up pins, since reset leaves inputs enabled
    for (int p = 0; p < 6; p++) begin
      s = reg_sel_t'(p % 3 + 2 + p / 3 * 3);
      rd(s, p % 3 == 1 ? 8'h00 : 8'hFF, "bc reset");
    end
    b_ext = 8'h5A;
    c_ext = 8'hC3;
    wr(REG_B_DIR, 8'h00);
    wr(REG_B_IE, 8'hF0);
    wr(REG_C_DIR, 8'h00);
    wr(REG_C_IE, 8'h0F);
    repeat (4) cyc(); // No conversion runs while ports are written
    rd(REG_B_DATA, 8'h50, "b analog");
    rd(REG_C_DATA, 8'h03, "c analog");
    `CHK("b ie", 8'hF0, b_ie)
    `CHK("c ie", 8'h0F, c_ie)
    repeat (8) begin
      lat = $urandom;
      a_ext = $urandom;
      wr(REG_A_LATCH, lat);
      wr(REG_A_PIN, ~lat);
      repeat (4) cyc();
      `CHK("a oe_n", lat[4:0], a_oe_n)
      `CHK("a o", 5'h00, a_o)
      rd(REG_A_LATCH, {3'h7, lat[4:0]}, "a latch");
      rd(REG_A_PIN, {3'h7, lat[4:0] & a_ext}, "a pin");
    end
    repeat (48) begin
      {dir, ie, lat, ext, i, c} = {$urandom, $urandom};
      s = c ? REG_C_DATA : REG_B_DATA;
      if (c) c_ext = ext;
      else b_ext = ext;
      wr(s, lat);
      wr(reg_sel_t'(s + 3'h1), dir);
      wr(reg_sel_t'(s + 3'h2), ie);
      repeat (4) cyc();
      `CHK("oe_n", ~dir, c ? c_oe_n : b_oe_n)
      `CHK("drive", lat, c ? c_o : b_o)
      `CHK("ie", ie, c ? c_ie : b_ie)
      rd(s, view(dir, ie, lat, ext), "data");
      cyc();
      req_in.sel = s;
      bit_idx_in = i;
      bit_val_in = ext[0];
      bit_op_in  = 1'b1;
      cyc();
      bit_op_in = 1'b0;
      lat = view(dir, ie, lat, ext);
      lat[i] = ext[0];
      wr(reg_sel_t'(s + 3'h1), 8'hFF);
      rd(s, lat, "bit op");
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
